// ===== hw/triaxis_accel_output_regs.sv
// What this block does
// - Y filtered sample: high byte bits 11..4, low byte top nibble bits 3..0.
// - Z filtered sample split the same way over its low and high bytes.
// - Unfiltered X sample split over low and high read-only bytes.
// - Unfiltered Y sample bits 11..4 readable in its high byte.
// - Unfiltered Z sample split over its low and high bytes.
// - Self-check byte reads the default pattern while trigger is clear.
// - Setting the self-check trigger turns the byte to the inverted pattern.
// - Reading the self-check byte restores the default pattern afterwards.
// - Self-check byte is read-only and resets to the default pattern.
// - Read-only identity byte holds a fixed supplier code.
// - Orientation refreshes once per rate period, never during a read.
// - Orientation holds six one-hot bits, top two zero, resets to 0x20.
// - Samples are twos complement, spanning -2048 to 2047.
// - Low resolution leaves only eight valid bits; high gives all twelve.
// - Samples update once per rate period, protected during reads.
module triaxis_accel_output_regs
#(
  parameter int unsigned ODR_PERIOD = accel_out_pkg::ODR_CYCLES,
  parameter logic [7:0] IDENTITY_CODE = accel_out_pkg::IDENTITY_DEFAULT
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [accel_out_pkg::ADDR_W-1:0] regAddr,
  input wire logic regRd,
  input wire logic regWr,
  input wire logic [accel_out_pkg::DATA_W-1:0] regWrData,
  input wire logic readBusy,
  input wire logic [accel_out_pkg::SAMPLE_W-1:0] xHpfSample,
  input wire logic [accel_out_pkg::SAMPLE_W-1:0] yHpfSample,
  input wire logic [accel_out_pkg::SAMPLE_W-1:0] zHpfSample,
  input wire logic [accel_out_pkg::SAMPLE_W-1:0] xSample,
  input wire logic [accel_out_pkg::SAMPLE_W-1:0] ySample,
  input wire logic [accel_out_pkg::SAMPLE_W-1:0] zSample,
  input wire logic [accel_out_pkg::ORIENT_W-1:0] orientationIn,
  output logic [accel_out_pkg::DATA_W-1:0] regRdData,
  output logic regRdValid
);
  import accel_out_pkg::*;

  logic odrTick;
  logic [SAMPLE_W-1:0] sampleIn [NUM_CH];
  logic [SAMPLE_W-1:0] heldSample [NUM_CH];
  logic [ORIENT_W-1:0] orientationCur;
  logic [7:0] firstControl_reg;
  logic [7:0] thirdControl_reg;
  logic [7:0] selfcheck_reg;
  logic [7:0] selfcheck_next;
  logic [7:0] thirdControl_next;

  // Twos complement samples pass through untouched; sign lives in bit 11
  assign sampleIn[CH_X_HPF] = xHpfSample;
  assign sampleIn[CH_Y_HPF] = yHpfSample;
  assign sampleIn[CH_Z_HPF] = zHpfSample;
  assign sampleIn[CH_X] = xSample;
  assign sampleIn[CH_Y] = ySample;
  assign sampleIn[CH_Z] = zSample;

  odr_tick #(
    .PERIOD(ODR_PERIOD)
  ) u_rate (
    .clk(clk),
    .nrst(nrst),
    .tick(odrTick)
  );

  // Held copies change on a rate tick outside a host read burst, or on the first cycle after a burst that deferred one
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_axis
    held_sample #(
      .WIDTH(SAMPLE_W),
      .RESET_VALUE(SAMPLE_RESET)
    ) u_hold (
      .clk(clk),
      .nrst(nrst),
      .captureTick(odrTick),
      .hold(readBusy),
      .sampleIn(sampleIn[ch]),
      .sampleOut(heldSample[ch])
    );
  end

  held_sample #(
    .WIDTH(ORIENT_W),
    .RESET_VALUE(ORIENT_RESET)
  ) u_orient (
    .clk(clk),
    .nrst(nrst),
    .captureTick(odrTick),
    .hold(readBusy),
    .sampleIn(orientationIn),
    .sampleOut(orientationCur)
  );

  wire resolutionHigh = firstControl_reg[RESOLUTION_SELECT_BIT];
  wire selfcheckTrigger = thirdControl_reg[SELFCHECK_TRIGGER_BIT];

  function automatic logic [7:0] highByte(input logic [SAMPLE_W-1:0] s);
    return s[SAMPLE_W-1:LOW_NIBBLE_POS];
  endfunction

  // Low nibble of a sample is only valid in high-resolution mode
  function automatic logic [7:0] lowByte(input logic [SAMPLE_W-1:0] s, input logic hiRes);
    return hiRes ? {s[LOW_NIBBLE_POS-1:0], 4'h0} : 8'h00;
  endfunction

  function automatic logic [7:0] readMux(
    input logic [7:0] addr,
    input logic hiRes,
    input logic [SAMPLE_W-1:0] xh,
    input logic [SAMPLE_W-1:0] yh,
    input logic [SAMPLE_W-1:0] zh,
    input logic [SAMPLE_W-1:0] xr,
    input logic [SAMPLE_W-1:0] yr,
    input logic [SAMPLE_W-1:0] zr,
    input logic [ORIENT_W-1:0] orient,
    input logic [7:0] check,
    input logic [7:0] ident,
    input logic [7:0] ctl1,
    input logic [7:0] ctl3
  );
    logic [7:0] d;
    d = 8'h00;
    unique case (addr)
      X_HPF_LOW_ADDR: d = lowByte(xh, hiRes);
      X_HPF_HIGH_ADDR: d = highByte(xh);
      Y_HPF_LOW_ADDR: d = lowByte(yh, hiRes);
      Y_HPF_HIGH_ADDR: d = highByte(yh);
      Z_HPF_LOW_ADDR: d = lowByte(zh, hiRes);
      Z_HPF_HIGH_ADDR: d = highByte(zh);
      X_LOW_ADDR: d = lowByte(xr, hiRes);
      X_HIGH_ADDR: d = highByte(xr);
      Y_LOW_ADDR: d = lowByte(yr, hiRes);
      Y_HIGH_ADDR: d = highByte(yr);
      Z_LOW_ADDR: d = lowByte(zr, hiRes);
      Z_HIGH_ADDR: d = highByte(zr);
      SELFCHECK_ADDR: d = check;
      IDENTITY_ADDR: d = ident;
      ORIENT_CUR_ADDR: d = {2'b00, orient};
      FIRST_CONTROL_ADDR: d = ctl1;
      THIRD_CONTROL_ADDR: d = ctl3;
      default: d = 8'h00;
    endcase
    return d;
  endfunction

  wire [7:0] readByte = readMux(regAddr, resolutionHigh,
    heldSample[CH_X_HPF], heldSample[CH_Y_HPF], heldSample[CH_Z_HPF],
    heldSample[CH_X], heldSample[CH_Y], heldSample[CH_Z],
    orientationCur, selfcheck_reg, IDENTITY_CODE, firstControl_reg, thirdControl_reg);

  wire wrFirst = regWr && (regAddr == FIRST_CONTROL_ADDR);
  wire wrThird = regWr && (regAddr == THIRD_CONTROL_ADDR);
  wire trigSet = wrThird && regWrData[SELFCHECK_TRIGGER_BIT];
  wire rdCheck = regRd && (regAddr == SELFCHECK_ADDR);
  // Writing the trigger back to zero also brings the default pattern back
  wire trigClear = wrThird && !regWrData[SELFCHECK_TRIGGER_BIT];

  // Trigger write wins over a simultaneous restoring read, so no set is lost
  assign selfcheck_next = trigSet ? SELFCHECK_INVERTED :
                          rdCheck ? SELFCHECK_PATTERN :
                          trigClear ? SELFCHECK_PATTERN :
                          selfcheck_reg;

  // Restoring read also drops the trigger, so a clear trigger always goes with the default pattern
  assign thirdControl_next = wrThird ? regWrData :
                             rdCheck ? (thirdControl_reg & ~(8'h01 << SELFCHECK_TRIGGER_BIT)) :
                             thirdControl_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      firstControl_reg <= FIRST_CONTROL_RESET;
      thirdControl_reg <= THIRD_CONTROL_RESET;
      selfcheck_reg <= SELFCHECK_PATTERN;
    end else begin
      if (wrFirst) begin
        firstControl_reg <= regWrData;
      end
      thirdControl_reg <= thirdControl_next;
      selfcheck_reg <= selfcheck_next;
    end
  end

  // Byte returned is the value before any restore takes effect
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      regRdData <= 8'h00;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRd;
      if (regRd) begin
        regRdData <= readByte;
      end
    end
  end

  property p_check_inverted;
    @(posedge clk) disable iff (!nrst)
      trigSet |=> (selfcheck_reg == SELFCHECK_INVERTED) && selfcheckTrigger;
  endproperty
  a_check_inverted: assert property (p_check_inverted) else $error("trigger did not invert");

  property p_check_restore;
    @(posedge clk) disable iff (!nrst)
      (rdCheck && !regWr) |=> (regRdData == $past(selfcheck_reg))
        && (selfcheck_reg == SELFCHECK_PATTERN) && regRdValid;
  endproperty
  a_check_restore: assert property (p_check_restore) else $error("read did not restore pattern");

  property p_check_default;
    @(posedge clk) disable iff (!nrst)
      !selfcheckTrigger |-> (selfcheck_reg == SELFCHECK_PATTERN);
  endproperty
  a_check_default: assert property (p_check_default) else $error("pattern wrong while idle");

  property p_check_values;
    @(posedge clk) disable iff (!nrst)
      (selfcheck_reg == SELFCHECK_PATTERN) || (selfcheck_reg == SELFCHECK_INVERTED);
  endproperty
  a_check_values: assert property (p_check_values) else $error("illegal self-check byte");

  property p_identity;
    @(posedge clk) disable iff (!nrst)
      (regRd && regAddr == IDENTITY_ADDR) |=> (regRdData == IDENTITY_CODE);
  endproperty
  a_identity: assert property (p_identity) else $error("identity byte wrong");

  property p_orient_top;
    @(posedge clk) disable iff (!nrst)
      (regRd && regAddr == ORIENT_CUR_ADDR) |=> (regRdData == {2'b00, $past(orientationCur)});
  endproperty
  a_orient_top: assert property (p_orient_top) else $error("orientation byte wrong");

  property p_y_hpf_high;
    @(posedge clk) disable iff (!nrst)
      (regRd && regAddr == Y_HPF_HIGH_ADDR) |=> (regRdData == $past(heldSample[CH_Y_HPF][11:4]));
  endproperty
  a_y_hpf_high: assert property (p_y_hpf_high) else $error("Y filtered high byte wrong");

  property p_z_low;
    @(posedge clk) disable iff (!nrst)
      (regRd && regAddr == Z_LOW_ADDR && resolutionHigh)
        |=> (regRdData == {$past(heldSample[CH_Z][3:0]), 4'h0});
  endproperty
  a_z_low: assert property (p_z_low) else $error("Z low byte wrong");

  property p_low_res;
    @(posedge clk) disable iff (!nrst)
      (regRd && !resolutionHigh && (regAddr == X_LOW_ADDR || regAddr == Y_HPF_LOW_ADDR))
        |=> (regRdData == 8'h00);
  endproperty
  a_low_res: assert property (p_low_res) else $error("low resolution nibble visible");

  property p_low_nibble_zero;
    @(posedge clk) disable iff (!nrst)
      (regRd && regAddr <= Z_LOW_ADDR && !regAddr[0]) |=> (regRdData[3:0] == 4'h0);
  endproperty
  a_low_nibble_zero: assert property (p_low_nibble_zero) else $error("low nibble not zero");

  property p_x_high;
    @(posedge clk) disable iff (!nrst)
      (regRd && regAddr == X_HIGH_ADDR)
        |=> (regRdData == $past(heldSample[CH_X][11:4]));
  endproperty
  a_x_high: assert property (p_x_high) else $error("X high byte wrong");

  property p_x_low;
    @(posedge clk) disable iff (!nrst)
      (regRd && regAddr == X_LOW_ADDR && resolutionHigh)
        |=> (regRdData == {$past(heldSample[CH_X][3:0]), 4'h0});
  endproperty
  a_x_low: assert property (p_x_low) else $error("X low byte wrong");

  property p_y_hpf_low;
    @(posedge clk) disable iff (!nrst)
      (regRd && regAddr == Y_HPF_LOW_ADDR && resolutionHigh)
        |=> (regRdData == {$past(heldSample[CH_Y_HPF][3:0]), 4'h0});
  endproperty
  a_y_hpf_low: assert property (p_y_hpf_low) else $error("Y filtered low byte wrong");

  property p_z_hpf_high;
    @(posedge clk) disable iff (!nrst)
      (regRd && regAddr == Z_HPF_HIGH_ADDR)
        |=> (regRdData == $past(heldSample[CH_Z_HPF][11:4]));
  endproperty
  a_z_hpf_high: assert property (p_z_hpf_high) else $error("Z filtered high byte wrong");

  property p_z_hpf_low;
    @(posedge clk) disable iff (!nrst)
      (regRd && regAddr == Z_HPF_LOW_ADDR && resolutionHigh)
        |=> (regRdData == {$past(heldSample[CH_Z_HPF][3:0]), 4'h0});
  endproperty
  a_z_hpf_low: assert property (p_z_hpf_low) else $error("Z filtered low byte wrong");

  property p_y_high;
    @(posedge clk) disable iff (!nrst)
      (regRd && regAddr == Y_HIGH_ADDR)
        |=> (regRdData == $past(heldSample[CH_Y][11:4]));
  endproperty
  a_y_high: assert property (p_y_high) else $error("Y high byte wrong");

  property p_z_high;
    @(posedge clk) disable iff (!nrst)
      (regRd && regAddr == Z_HIGH_ADDR)
        |=> (regRdData == $past(heldSample[CH_Z][11:4]));
  endproperty
  a_z_high: assert property (p_z_high) else $error("Z high byte wrong");

  property p_trigger_clear;
    @(posedge clk) disable iff (!nrst)
      (trigClear && !trigSet)
        |=> (selfcheck_reg == SELFCHECK_PATTERN) && !selfcheckTrigger;
  endproperty
  a_trigger_clear: assert property (p_trigger_clear) else $error("cleared trigger kept");

  property p_orient_hold;
    @(posedge clk) disable iff (!nrst)
      readBusy |=> $stable(orientationCur);
  endproperty
  a_orient_hold: assert property (p_orient_hold) else $error("orientation moved in read");
endmodule

// ===== hw/accel_out_pkg.sv
package accel_out_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int SAMPLE_W = 12;
  localparam int ORIENT_W = 6;

  // Register offsets
  localparam logic [7:0] X_HPF_LOW_ADDR = 8'h00;
  localparam logic [7:0] X_HPF_HIGH_ADDR = 8'h01;
  localparam logic [7:0] Y_HPF_LOW_ADDR = 8'h02;
  localparam logic [7:0] Y_HPF_HIGH_ADDR = 8'h03;
  localparam logic [7:0] Z_HPF_LOW_ADDR = 8'h04;
  localparam logic [7:0] Z_HPF_HIGH_ADDR = 8'h05;
  localparam logic [7:0] X_LOW_ADDR = 8'h06;
  localparam logic [7:0] X_HIGH_ADDR = 8'h07;
  localparam logic [7:0] Y_LOW_ADDR = 8'h08;
  localparam logic [7:0] Y_HIGH_ADDR = 8'h09;
  localparam logic [7:0] Z_LOW_ADDR = 8'h0A;
  localparam logic [7:0] Z_HIGH_ADDR = 8'h0B;
  localparam logic [7:0] SELFCHECK_ADDR = 8'h0C;
  localparam logic [7:0] IDENTITY_ADDR = 8'h0F;
  localparam logic [7:0] ORIENT_CUR_ADDR = 8'h10;
  localparam logic [7:0] FIRST_CONTROL_ADDR = 8'h1B;
  localparam logic [7:0] THIRD_CONTROL_ADDR = 8'h1D;

  // Field positions
  localparam int RESOLUTION_SELECT_BIT = 6;
  localparam int SELFCHECK_TRIGGER_BIT = 4;
  localparam int LOW_NIBBLE_POS = 4;

  // Reset and fixed values
  localparam logic [7:0] SELFCHECK_PATTERN = 8'h55;
  localparam logic [7:0] SELFCHECK_INVERTED = 8'hAA;
  localparam logic [5:0] ORIENT_RESET = 6'h20;
  localparam logic [7:0] FIRST_CONTROL_RESET = 8'h00;
  localparam logic [7:0] THIRD_CONTROL_RESET = 8'h4D;
  localparam logic [11:0] SAMPLE_RESET = 12'h000;
  // Arbitrary neutral value, not a real supplier code
  localparam logic [7:0] IDENTITY_DEFAULT = 8'h3C;

  // Output data rate timing
  localparam int CLK_HZ = 50_000_000;
  localparam int ODR_HZ = 25;
  localparam int ODR_CYCLES = CLK_HZ / ODR_HZ;

  // Sample channel indices
  typedef enum logic [2:0] {
    CH_X_HPF,
    CH_Y_HPF,
    CH_Z_HPF,
    CH_X,
    CH_Y,
    CH_Z
  } channel_t;

  localparam int NUM_CH = 6;

endpackage

// ===== hw/odr_tick.sv
module odr_tick #(
  parameter int unsigned PERIOD = 2_000_000
) (
  input wire logic clk,
  input wire logic nrst,
  output logic tick
);
  localparam int CW = (PERIOD > 1) ? $clog2(PERIOD) : 1;
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  wire atLast = (count_reg == LAST);

  assign count_next = atLast ? '0 : count_reg + CW'(1);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_reg <= '0;
      tick <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick <= atLast;
    end
  end

  // Ticks are exactly one period apart
  property p_tick_period;
    @(posedge clk) disable iff (!nrst)
      tick |-> (count_reg == '0) || (PERIOD == 1);
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("rate tick off its period");
endmodule

// ===== hw/held_sample.sv
module held_sample #(
  parameter int WIDTH = 12,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic captureTick,
  input wire logic hold,
  input wire logic [WIDTH-1:0] sampleIn,
  output logic [WIDTH-1:0] sampleOut
);
  logic pending_reg;
  // A tick during a read is deferred, not dropped; several ticks in one burst merge into one capture after it
  wire want = captureTick | pending_reg;
  wire capture = want & ~hold;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pending_reg <= 1'b0;
      sampleOut <= RESET_VALUE;
    end else begin
      pending_reg <= want & hold;
      if (capture) begin
        sampleOut <= sampleIn;
      end
    end
  end

  property p_stable_in_read;
    @(posedge clk) disable iff (!nrst)
      hold |=> $stable(sampleOut);
  endproperty
  a_stable_in_read: assert property (p_stable_in_read) else $error("sample changed during read");

  property p_deferred_capture;
    @(posedge clk) disable iff (!nrst)
      (captureTick && hold) ##1 (!hold) |=> (sampleOut == $past(sampleIn));
  endproperty
  a_deferred_capture: assert property (p_deferred_capture) else $error("deferred sample lost");
endmodule

// ===== sim/host_model.sv
module host_model
(
  input wire logic clk,
  output logic [accel_out_pkg::ADDR_W-1:0] regAddr,
  output logic regRd,
  output logic regWr,
  output logic [accel_out_pkg::DATA_W-1:0] regWrData,
  output logic readBusy,
  input wire logic [accel_out_pkg::DATA_W-1:0] regRdData,
  input wire logic regRdValid
);
  timeunit 1ns;
  timeprecision 100ps;
  import accel_out_pkg::*;

  initial begin
    regAddr = '0;
    regRd = 1'b0;
    regWr = 1'b0;
    regWrData = '0;
    readBusy = 1'b0;
  end

  // Released lines show the inverse, so a stale value never passes
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
    int i;
    @(posedge clk);
    #1;
    regAddr = a;
    regRd = 1'b1;
    @(posedge clk);
    #1;
    regRd = 1'b0;
    regAddr = ~a;
    ok = 1'b0;
    d = '0;
    for (i = 0; i < 3 && !ok; i++) begin
      if (regRdValid === 1'b1) begin
        ok = 1'b1;
        d = regRdData;
      end else begin
        @(posedge clk);
        #1;
      end
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    regAddr = a;
    regWrData = d;
    regWr = 1'b1;
    @(posedge clk);
    #1;
    regWr = 1'b0;
    regAddr = ~a;
    regWrData = ~d;
  endtask

  task automatic busy(input logic b);
    @(posedge clk);
    #1;
    readBusy = b;
  endtask
endmodule

// ===== sim/triaxis_accel_output_regs_tb.sv
module triaxis_accel_output_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import accel_out_pkg::*;
  localparam int unsigned PER = 10;
  // Arbitrary value, not a real supplier code
  localparam logic [7:0] ID_CODE = 8'h9A;
  localparam logic [7:0] LOW_A [6] = '{X_HPF_LOW_ADDR, Y_HPF_LOW_ADDR, Z_HPF_LOW_ADDR,
    X_LOW_ADDR, Y_LOW_ADDR, Z_LOW_ADDR};
  localparam logic [7:0] HIGH_A [6] = '{X_HPF_HIGH_ADDR, Y_HPF_HIGH_ADDR, Z_HPF_HIGH_ADDR,
    X_HIGH_ADDR, Y_HIGH_ADDR, Z_HIGH_ADDR};
  logic clk, nrst, regRd, regWr, readBusy, regRdValid;
  logic [7:0] regAddr, regWrData, regRdData, d;
  logic [11:0] smp [6];
  logic [11:0] expS [6];
  logic [5:0] orient, expO;
  logic [31:0] seed;
  int n_fail, checks, it;
  bit ok;
  wire [11:0] xHpf = smp[0];
  wire [11:0] yHpf = smp[1];
  wire [11:0] zHpf = smp[2];
  wire [11:0] xRaw = smp[3];
  wire [11:0] yRaw = smp[4];
  wire [11:0] zRaw = smp[5];

  triaxis_accel_output_regs #(.ODR_PERIOD(PER), .IDENTITY_CODE(ID_CODE)) dut_u (
    .clk(clk), .nrst(nrst), .regAddr(regAddr), .regRd(regRd), .regWr(regWr),
    .regWrData(regWrData), .readBusy(readBusy), .xHpfSample(xHpf), .yHpfSample(yHpf),
    .zHpfSample(zHpf), .xSample(xRaw), .ySample(yRaw), .zSample(zRaw),
    .orientationIn(orient), .regRdData(regRdData), .regRdValid(regRdValid));

  host_model host (.clk(clk), .regAddr(regAddr), .regRd(regRd), .regWr(regWr),
    .regWrData(regWrData), .readBusy(readBusy), .regRdData(regRdData),
    .regRdValid(regRdValid));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Low resolution blanks the whole low byte
  function automatic logic [7:0] expLow(input logic [11:0] s, input logic hi);
    return hi ? {s[3:0], 4'h0} : 8'h00;
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t read %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, d, ok);
    if (!ok) begin
      n_fail++;
      $display("[FAIL] %0t no read answer at %h", $time, a);
    end
    check(d, exp);
  endtask

  task automatic chkAll(input logic hi);
    int ch;
    for (ch = 0; ch < 6; ch++) begin
      rdChk(HIGH_A[ch], expS[ch][11:4]);
      rdChk(LOW_A[ch], expLow(expS[ch], hi));
    end
    rdChk(ORIENT_CUR_ADDR, {2'b00, expO});
  endtask

  task automatic newInputs(input int k);
    logic [31:0] r;
    int ch;
    @(posedge clk);
    #1;
    for (ch = 0; ch < 6; ch++) begin
      r = rnd();
      smp[ch] = (k == 0) ? 12'h800 : (k == 1) ? 12'h7FF : r[11:0];
    end
    r = rnd();
    orient = 6'h20 >> (r % 6);
  endtask

  task automatic results;
    if (n_fail == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    $display("[FAIL] %0t run did not finish", $time);
    results();
  end

  initial begin
    nrst = 1'b0;
    seed = 32'd78;
    n_fail = 0;
    checks = 0;
    orient = 6'h01;
    for (it = 0; it < 6; it++) smp[it] = 12'h000;
    repeat (5) @(posedge clk);
    #1;
    nrst = 1'b1;
    rdChk(ORIENT_CUR_ADDR, 8'h20);
    rdChk(SELFCHECK_ADDR, 8'h55);
    rdChk(IDENTITY_ADDR, ID_CODE);
    rdChk(8'h0D, 8'h00);
    host.wr(SELFCHECK_ADDR, 8'h00);
    rdChk(SELFCHECK_ADDR, 8'h55);
    host.wr(THIRD_CONTROL_ADDR, 8'h5D);
    rdChk(SELFCHECK_ADDR, 8'hAA);
    rdChk(SELFCHECK_ADDR, 8'h55);
    rdChk(THIRD_CONTROL_ADDR, 8'h4D);
    // Trigger cleared by a write, with no read in between
    host.wr(THIRD_CONTROL_ADDR, 8'h5D);
    host.wr(THIRD_CONTROL_ADDR, 8'h4D);
    rdChk(SELFCHECK_ADDR, 8'h55);
    for (it = 0; it < 6; it++) begin
      host.wr(FIRST_CONTROL_ADDR, it[0] ? 8'h40 : 8'h00);
      newInputs(it);
      repeat (2 * PER + 3) @(posedge clk);
      expS = smp;
      expO = orient;
      host.busy(1'b1);
      chkAll(it[0]);
      host.busy(1'b0);
    end
    // Inputs move during a long burst; stored bytes must not
    host.busy(1'b1);
    newInputs(2);
    repeat (2 * PER + 3) @(posedge clk);
    chkAll(1'b1);
    host.busy(1'b0);
    // Pending tick lands right after the burst ends
    repeat (3) @(posedge clk);
    expS = smp;
    expO = orient;
    host.busy(1'b1);
    chkAll(1'b1);
    host.busy(1'b0);
    // Reset in mid-run with the trigger set must bring every default back
    host.wr(THIRD_CONTROL_ADDR, 8'h5D);
    @(posedge clk);
    #1;
    nrst = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    nrst = 1'b1;
    rdChk(SELFCHECK_ADDR, 8'h55);
    rdChk(THIRD_CONTROL_ADDR, 8'h4D);
    rdChk(ORIENT_CUR_ADDR, 8'h20);
    rdChk(X_HIGH_ADDR, 8'h00);
    results();
  end
endmodule
